// ==== dv/interface_and_clock_config_tb.sv ====
`timescale 1ns/1ns
`include "iface_clk_cfg.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module interface_and_clock_config_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic txrx_pin = 1'b0;
  logic sen_n, sclk, sdio, sdo, sdo_oe_n;
  iface_clk_pkg::iface_ctl_t iface_ctl;
  iface_clk_pkg::clock_ctl_t clock_ctl;
  int miscompares = 0;
  int total_checks = 0;
  logic [7:0] io_s, ck_s, rd;
  // address, written value, expected readback
  logic [21:0] rows [10] = '{{6'h14, 8'h30, 8'h30}, {6'h14, 8'h04, 8'h04}, {6'h14, 8'h00, 8'h00},
    {6'h14, 8'h0A, 8'h0A}, {6'h14, 8'h15, 8'h15}, {6'h14, 8'hC4, 8'h04}, {6'h15, 8'h8A, 8'h8A},
    {6'h15, 8'h01, 8'h01}, {6'h15, 8'h30, 8'h30}, {6'h15, 8'h47, 8'h07}};

  always #5 clk = ~clk;

  interface_and_clock_config interface_and_clock_config_inst (.CLK(clk), .SYS_RST(sys_rst), .SEN_N(sen_n),
    .SCLK(sclk), .SDIO(sdio), .SDO(sdo), .SDO_OE_N(sdo_oe_n), .TXRX_PIN(txrx_pin), .IFACE_CTL(iface_ctl),
    .CLOCK_CTL(clock_ctl));
  serial_host serial_host_inst (.clk(clk), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .sen_n(sen_n), .sclk(sclk),
    .sdio(sdio));

  // ********************
  // expected decode
  // ********************
  function automatic iface_clk_pkg::iface_ctl_t exp_io(logic [7:0] v, logic pin);
    iface_clk_pkg::iface_ctl_t e;
    e.mode = v[0] ? iface_clk_pkg::CLONE_MODE : v[4] ? iface_clk_pkg::FULL_DUPLEX_MODE :
      v[2] ? iface_clk_pkg::HALF_DUPLEX_NARROW : iface_clk_pkg::HALF_DUPLEX_WIDE;
    e.hd_dir_tx = v[1] ? v[3] : pin;
    e.loopback_on = v[5];
    e.in_bus_fd_timing = v[5] | (e.mode == iface_clk_pkg::FULL_DUPLEX_MODE);
    e.rx_bus_from_tx_path = v[5];
    return e;
  endfunction : exp_io

  function automatic iface_clk_pkg::clock_ctl_t exp_clk(logic [7:0] v);
    iface_clk_pkg::clock_ctl_t e;
    e = {v[7], 1'b1, v[4], v[4], v[5], v[3], v[2:0], 3'h0};
    e.mult_factor = (v[2:0] == 3'h0) ? 3'h1 : (v[2:0] == 3'h1) ? 3'h2 : (v[2:0] == 3'h2) ? 3'h4 : 3'h0;
    return e;
  endfunction : exp_clk

  task automatic check_all(input string nm);
    `CHK("iface_ctl", exp_io(io_s, txrx_pin), iface_ctl)
    `CHK("clock_ctl", exp_clk(ck_s), clock_ctl)
    $display("test %s done", nm);
  endtask : check_all

  task automatic wr(input logic [5:0] a, input logic [7:0] d, input int n);
    serial_host_inst.xfer({2'b00, a}, d, n, rd);
    if (n == 16 && a == `IO_CFG_ADDR)
      io_s = d & `IO_CFG_MASK;
    if (n == 16 && a == `CLK_CFG_ADDR)
      ck_s = d & `CLK_CFG_MASK;
  endtask : wr

  task automatic rd_chk(input logic [5:0] a);
    serial_host_inst.xfer({2'b10, a}, 8'h00, 16, rd);
    `CHK("readback", (a == `IO_CFG_ADDR) ? io_s : (a == `CLK_CFG_ADDR) ? ck_s : 8'h00, rd)
  endtask : rd_chk

  task automatic results;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  initial
  begin
    #500000;
    miscompares++;
    results();
  end

  initial
  begin
    io_s = 8'h10;
    ck_s = 8'h00;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    check_all("reset");
    rd_chk(`IO_CFG_ADDR);
    rd_chk(`CLK_CFG_ADDR);
    // ********************
    // table of register settings
    // ********************
    foreach (rows[i])
    begin
      wr(rows[i][21:16], rows[i][15:8], 16);
      rd_chk(rows[i][21:16]);
      `CHK("row_readback", rows[i][7:0], rd)
      check_all("row");
    end
    // unmapped address neither stores nor disturbs
    wr(6'h16, 8'hFF, 16);
    rd_chk(6'h16);
    check_all("unmapped");
    // short frame must be dropped
    wr(`CLK_CFG_ADDR, 8'h02, 12);
    check_all("short");
    // external pin steers direction until overridden
    wr(`IO_CFG_ADDR, 8'h00, 16);
    txrx_pin = 1'b1;
    repeat (4) @(negedge clk);
    check_all("pin");
    wr(`IO_CFG_ADDR, 8'h02, 16);
    check_all("override");
    wr(`IO_CFG_ADDR, 8'h0E, 16);
    check_all("override tx");
    // second reset in mid-run
    sys_rst = 1'b1;
    @(negedge clk);
    `CHK("oe_in_reset", 1'b1, sdo_oe_n)
    sys_rst = 1'b0;
    io_s = 8'h10;
    ck_s = 8'h00;
    repeat (4) @(negedge clk);
    check_all("rereset");
    rd_chk(`IO_CFG_ADDR);
    results();
  end
endmodule : interface_and_clock_config_tb

// ==== dv/serial_host.sv ====
`timescale 1ns/1ns
`include "iface_clk_cfg.svh"
module serial_host (
  input wire logic clk,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  output logic sen_n,
  output logic sclk,
  output logic sdio
);
  // ********************
  // host side of the serial register port
  // ********************
  // clone mode is only entered together with clock mode 111, kept in a register not modelled here
  initial
  begin
    sen_n = 1'b1;
    sclk = 1'b0;
    sdio = 1'b0;
  end

  // n below 16 cuts the frame short; half period of 6 clk keeps sclk under the oversampling limit
  task automatic xfer(input logic [7:0] ins, input logic [7:0] wd, input int n, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {ins, wd};
    if (!ins[7] && ins[5:0] == `IO_CFG_ADDR && wd[5])
      sh[4] = 1'b1;
    rd = 8'h00;
    @(negedge clk);
    sen_n = 1'b0;
    for (int i = 15; i > 15 - n; i--)
    begin
      sdio = sh[i];
      repeat (6) @(negedge clk);
      sclk = 1'b1;
      if (i < 8)
        rd[i] = sdo_oe_n ? 1'bx : sdo;
      repeat (6) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (6) @(negedge clk);
    sen_n = 1'b1;
    // released line must not keep showing the last bit
    sdio = ~sdio;
    repeat (6) @(negedge clk);
  endtask : xfer
endmodule : serial_host

// ==== logic/iface_clk_cfg.svh ====
// Function
// - loopback takes input bus with full-duplex timing through transmit path out receive bus
// - duplex select high means full duplex, low half duplex; resets high
// - duplex and width bits pick full, narrow or wide; clone ignores duplex bit
// - in half duplex, direction high means transmit, low means receive
// - width bit high selects 12-bit mode, low selects 24-bit mode
// - override bit makes register direction replace the external direction pin
// - bypass routes clocks around synthesizer, which keeps running
// - converter clock halve bit low passes source, high divides by two
// - converter clock source is primary input normally, synthesizer in alternative timing
// - alternative timing resets low; high makes synthesizer drive receive path
// - divide-by-five high divides synthesizer output by five; low passes it undivided
// - multiply field resets 000; 000 one-times, 001 two-times, 010 four-times
// - synthesizer output set jointly by multiply field and divide-by-five bit
`ifndef IFACE_CLK_CFG_SVH
`define IFACE_CLK_CFG_SVH

// ********************
// register map
// ********************
`define IO_CFG_ADDR 6'h14
`define CLK_CFG_ADDR 6'h15
`define IO_CFG_RST 8'h10
`define CLK_CFG_RST 8'h00
`define IO_CFG_MASK 8'h3F
`define CLK_CFG_MASK 8'hBF

// ********************
// field positions
// ********************
`define IO_LOOP_BIT 5
`define IO_DUPLEX_BIT 4
`define IO_DIR_BIT 3
`define IO_WIDTH_BIT 2
`define IO_OVERRIDE_BIT 1
`define IO_CLONE_BIT 0
`define CLK_BYPASS_BIT 7
`define CLK_HALVE_BIT 5
`define CLK_ALT_BIT 4
`define CLK_DIV5_BIT 3
`define CLK_MULT_HI 2
`define CLK_MULT_LO 0

// ********************
// multiply codes and factors
// ********************
`define MULT_CODE_X1 3'h0
`define MULT_CODE_X2 3'h1
`define MULT_CODE_X4 3'h2
`define MULT_FACTOR_X1 3'h1
`define MULT_FACTOR_X2 3'h2
`define MULT_FACTOR_X4 3'h4
`define MULT_FACTOR_NONE 3'h0

// ********************
// serial port framing
// ********************
`define SER_CNT_W 5
`define SER_INSTR_EDGES 5'h08
`define SER_BYTE1_EDGES 5'h10
`define SER_BYTE2_EDGES 5'h18
`define SER_CNT_MAX 5'h1F
`define SER_RW_BIT 7
`define SER_TWO_BYTE_BIT 6

`endif

// ==== logic/iface_clk_pkg.sv ====
package iface_clk_pkg;

  typedef enum logic [1:0] {
    FULL_DUPLEX_MODE,
    HALF_DUPLEX_NARROW,
    HALF_DUPLEX_WIDE,
    CLONE_MODE
  } if_mode_t;

  typedef struct packed {
    logic en;
    logic [5:0] addr;
    logic [7:0] data;
  } reg_wr_t;

  typedef struct packed {
    if_mode_t mode;
    logic hd_dir_tx;
    logic loopback_on;
    logic in_bus_fd_timing;
    logic rx_bus_from_tx_path;
  } iface_ctl_t;

  typedef struct packed {
    logic synth_bypass;
    logic synth_running;
    logic rx_src_synth;
    logic adc_src_synth;
    logic adc_div2;
    logic synth_div5;
    logic [2:0] mult_code;
    logic [2:0] mult_factor;
  } clock_ctl_t;

endpackage : iface_clk_pkg

// ==== logic/interface_and_clock_config.sv ====
`timescale 1ns/1ns
`include "iface_clk_cfg.svh"
module interface_and_clock_config (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic SEN_N,
  input wire logic SCLK,
  input wire logic SDIO,
  output logic SDO,
  output logic SDO_OE_N,
  input wire logic TXRX_PIN,
  output iface_clk_pkg::iface_ctl_t IFACE_CTL,
  output iface_clk_pkg::clock_ctl_t CLOCK_CTL
);
  // ********************
  // register access
  // ********************
  iface_clk_pkg::reg_wr_t wr;
  logic [5:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] io_r, clk_r;
  logic txrx_s1_r, txrx_s2_r;
  iface_clk_pkg::iface_ctl_t iface_r, iface_nxt;
  iface_clk_pkg::clock_ctl_t clock_r, clock_nxt;

  // the serial port is oversampled on the system clock, so no second clock domain reaches here
  serial_reg_port serial_reg_port_inst (
    .clk(CLK),
    .rst(SYS_RST),
    .sen_n(SEN_N),
    .sclk(SCLK),
    .sdio(SDIO),
    .sdo(SDO),
    .sdo_oe_n(SDO_OE_N),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .wr(wr)
  );

  wire wr_io = wr.en && (wr.addr == `IO_CFG_ADDR);
  wire wr_clk = wr.en && (wr.addr == `CLK_CFG_ADDR);
  // unmapped addresses read back zero
  assign rd_data = (rd_addr == `IO_CFG_ADDR) ? io_r :
                   (rd_addr == `CLK_CFG_ADDR) ? clk_r : 8'h00;

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      io_r <= `IO_CFG_RST;
      clk_r <= `CLK_CFG_RST;
    end
    else
    begin
      if (wr_io)
        io_r <= wr.data & `IO_CFG_MASK;
      if (wr_clk)
        clk_r <= wr.data & `CLK_CFG_MASK;
    end
  end

  // ********************
  // interface mode decode
  // ********************
  wire loop_on = io_r[`IO_LOOP_BIT];
  wire duplex_select = io_r[`IO_DUPLEX_BIT];
  wire half_duplex_direction = io_r[`IO_DIR_BIT];
  wire word_width_select = io_r[`IO_WIDTH_BIT];
  wire dir_override = io_r[`IO_OVERRIDE_BIT];
  wire clone_mode_enable = io_r[`IO_CLONE_BIT];
  // clock mode field 111 lives in another register; clone here trusts software set it
  wire [1:0] mode_sel = clone_mode_enable ? iface_clk_pkg::CLONE_MODE :
                        duplex_select ? iface_clk_pkg::FULL_DUPLEX_MODE :
                        word_width_select ? iface_clk_pkg::HALF_DUPLEX_NARROW :
                        iface_clk_pkg::HALF_DUPLEX_WIDE;
  wire dir_sel = dir_override ? half_duplex_direction : txrx_s2_r;

  always_comb
  begin
    iface_nxt.mode = iface_clk_pkg::if_mode_t'(mode_sel);
    iface_nxt.hd_dir_tx = dir_sel;
    iface_nxt.loopback_on = loop_on;
    // loopback forces full-duplex input timing even if software left half duplex set
    iface_nxt.in_bus_fd_timing = loop_on | (mode_sel == iface_clk_pkg::FULL_DUPLEX_MODE);
    iface_nxt.rx_bus_from_tx_path = loop_on;
  end

  // ********************
  // clock tree decode
  // ********************
  function automatic logic [2:0] mult_factor(input logic [2:0] code);
    unique case (code)
      `MULT_CODE_X1: mult_factor = `MULT_FACTOR_X1;
      `MULT_CODE_X2: mult_factor = `MULT_FACTOR_X2;
      `MULT_CODE_X4: mult_factor = `MULT_FACTOR_X4;
      default: mult_factor = `MULT_FACTOR_NONE;
    endcase
  endfunction : mult_factor

  wire alt_timing = clk_r[`CLK_ALT_BIT];

  always_comb
  begin
    clock_nxt.synth_bypass = clk_r[`CLK_BYPASS_BIT];
    clock_nxt.synth_running = 1'b1;
    clock_nxt.rx_src_synth = alt_timing;
    clock_nxt.adc_src_synth = alt_timing;
    clock_nxt.adc_div2 = clk_r[`CLK_HALVE_BIT];
    clock_nxt.synth_div5 = clk_r[`CLK_DIV5_BIT];
    clock_nxt.mult_code = clk_r[`CLK_MULT_HI:`CLK_MULT_LO];
    clock_nxt.mult_factor = mult_factor(clk_r[`CLK_MULT_HI:`CLK_MULT_LO]);
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      txrx_s1_r <= 1'b0;
      txrx_s2_r <= 1'b0;
      iface_r <= '0;
      clock_r <= '0;
    end
    else
    begin
      txrx_s1_r <= TXRX_PIN;
      txrx_s2_r <= txrx_s1_r;
      iface_r <= iface_nxt;
      clock_r <= clock_nxt;
    end
  end

  assign IFACE_CTL = iface_r;
  assign CLOCK_CTL = clock_r;

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  chk_loop_path: assert property (io_r[`IO_LOOP_BIT] |=> IFACE_CTL.rx_bus_from_tx_path && IFACE_CTL.in_bus_fd_timing)
    else $error("loopback did not route tx path to rx bus");
  chk_duplex_full: assert property ((wr_io && wr.data[`IO_DUPLEX_BIT] && !wr.data[`IO_CLONE_BIT])
      |-> ##2 IFACE_CTL.mode == iface_clk_pkg::FULL_DUPLEX_MODE)
    else $error("duplex write did not select full duplex");
  chk_clone_wins: assert property (io_r[`IO_CLONE_BIT] |=> IFACE_CTL.mode == iface_clk_pkg::CLONE_MODE)
    else $error("clone mode not honoured");
  chk_width_narrow: assert property ((io_r[`IO_WIDTH_BIT] && !io_r[`IO_DUPLEX_BIT] && !io_r[`IO_CLONE_BIT])
      |=> IFACE_CTL.mode == iface_clk_pkg::HALF_DUPLEX_NARROW)
    else $error("width bit did not select narrow half duplex");
  chk_dir_override: assert property (io_r[`IO_OVERRIDE_BIT]
      |=> IFACE_CTL.hd_dir_tx == $past(io_r[`IO_DIR_BIT]))
    else $error("override did not use register direction");
  chk_dir_pin: assert property (!io_r[`IO_OVERRIDE_BIT] |=> IFACE_CTL.hd_dir_tx == $past(txrx_s2_r))
    else $error("direction did not follow pin");
  chk_bypass_runs: assert property (clk_r[`CLK_BYPASS_BIT] |=> CLOCK_CTL.synth_bypass && CLOCK_CTL.synth_running)
    else $error("bypass stopped synthesizer");
  chk_adc_halve: assert property (CLOCK_CTL.adc_div2 == $past(clk_r[`CLK_HALVE_BIT]))
    else $error("converter halve mismatch");
  chk_alt_source: assert property (clk_r[`CLK_ALT_BIT] |=> CLOCK_CTL.rx_src_synth && CLOCK_CTL.adc_src_synth)
    else $error("alternative timing source not selected");
  chk_div5_sel: assert property ($rose(clk_r[`CLK_DIV5_BIT]) |=> $rose(CLOCK_CTL.synth_div5))
    else $error("divide by five not applied");
  chk_mult_x4: assert property ((clk_r[`CLK_MULT_HI:`CLK_MULT_LO] == `MULT_CODE_X4)
      |=> CLOCK_CTL.mult_factor == `MULT_FACTOR_X4)
    else $error("multiply code 010 not four times");
  chk_reserved_zero: assert property ((wr_io || wr_clk) |=> (io_r & ~`IO_CFG_MASK) == 8'h00
      && (clk_r & ~`CLK_CFG_MASK) == 8'h00)
    else $error("undefined bit stored");

  // ********************
  // reset and write checks
  // ********************
  // reset is asynchronous, so the first edge after release must already see the defaults
  chk_reset_values: assert property ($fell(SYS_RST)
      |-> io_r == `IO_CFG_RST && clk_r == `CLK_CFG_RST)
    else $error("registers missed their reset values");
  chk_io_write: assert property (wr_io
      |=> io_r == ($past(wr.data) & `IO_CFG_MASK))
    else $error("interface register write did not land");
  chk_clock_write: assert property (wr_clk
      |=> clk_r == ($past(wr.data) & `CLK_CFG_MASK))
    else $error("clock register write did not land");

  // ********************
  // interface checks
  // ********************
  chk_half_wide: assert property ((!io_r[`IO_DUPLEX_BIT] && !io_r[`IO_WIDTH_BIT] && !io_r[`IO_CLONE_BIT])
      |=> IFACE_CTL.mode == iface_clk_pkg::HALF_DUPLEX_WIDE)
    else $error("half duplex wide mode not selected");
  chk_loop_off: assert property (!io_r[`IO_LOOP_BIT]
      |=> !IFACE_CTL.loopback_on && !IFACE_CTL.rx_bus_from_tx_path)
    else $error("loopback path active while disabled");
  chk_fd_timing: assert property ((io_r[`IO_DUPLEX_BIT] && !io_r[`IO_CLONE_BIT])
      |=> IFACE_CTL.in_bus_fd_timing)
    else $error("full duplex input timing not selected");

  // ********************
  // clock checks
  // ********************
  chk_bypass_off: assert property (!clk_r[`CLK_BYPASS_BIT]
      |=> !CLOCK_CTL.synth_bypass && CLOCK_CTL.synth_running)
    else $error("synthesizer bypassed or stopped while not asked");
  chk_normal_source: assert property (!clk_r[`CLK_ALT_BIT]
      |=> !CLOCK_CTL.rx_src_synth && !CLOCK_CTL.adc_src_synth)
    else $error("normal timing did not use primary clock input");
  chk_div5_off: assert property (!clk_r[`CLK_DIV5_BIT] |=> !CLOCK_CTL.synth_div5)
    else $error("divide by five applied while off");
  // codes above four times report factor zero, so an unsupported setting stays visible
  chk_mult_x1: assert property ((clk_r[`CLK_MULT_HI:`CLK_MULT_LO] == `MULT_CODE_X1)
      |=> CLOCK_CTL.mult_factor == `MULT_FACTOR_X1)
    else $error("multiply code 000 not one times");
  chk_mult_x2: assert property ((clk_r[`CLK_MULT_HI:`CLK_MULT_LO] == `MULT_CODE_X2)
      |=> CLOCK_CTL.mult_factor == `MULT_FACTOR_X2)
    else $error("multiply code 001 not two times");
  chk_mult_code: assert property (CLOCK_CTL.mult_code == $past(clk_r[`CLK_MULT_HI:`CLK_MULT_LO]))
    else $error("multiply code not passed on");

  cov_loopback: cover property (wr_io && wr.data[`IO_LOOP_BIT] ##2 IFACE_CTL.loopback_on);
  cov_clone: cover property (IFACE_CTL.mode == iface_clk_pkg::CLONE_MODE);
  cov_half_wide: cover property (IFACE_CTL.mode == iface_clk_pkg::HALF_DUPLEX_WIDE);
  cov_bypass_div5: cover property (CLOCK_CTL.synth_bypass && CLOCK_CTL.synth_div5);
  cov_narrow_tx: cover property (IFACE_CTL.mode == iface_clk_pkg::HALF_DUPLEX_NARROW && IFACE_CTL.hd_dir_tx);

endmodule : interface_and_clock_config

// ==== logic/serial_reg_port.sv ====
`timescale 1ns/1ns
`include "iface_clk_cfg.svh"
module serial_reg_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic sen_n,
  input wire logic sclk,
  input wire logic sdio,
  output logic sdo,
  output logic sdo_oe_n,
  output logic [5:0] rd_addr,
  input wire logic [7:0] rd_data,
  output iface_clk_pkg::reg_wr_t wr
);
  // ********************
  // pin synchronisers
  // ********************
  logic sen_n_s1_r, sen_n_s2_r, sclk_s1_r, sclk_s2_r, sclk_s3_r, sdio_s1_r, sdio_s2_r;
  logic [`SER_CNT_W-1:0] cnt_r;
  logic [7:0] instr_r, shin_r, shout_r;
  logic [5:0] addr_r;
  logic sdo_r, oe_n_r;
  iface_clk_pkg::reg_wr_t wr_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sen_n_s1_r <= 1'b1;
      sen_n_s2_r <= 1'b1;
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      sdio_s1_r <= 1'b0;
      sdio_s2_r <= 1'b0;
    end
    else
    begin
      sen_n_s1_r <= sen_n;
      sen_n_s2_r <= sen_n_s1_r;
      sclk_s1_r <= sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      sdio_s1_r <= sdio;
      sdio_s2_r <= sdio_s1_r;
    end
  end

  // ********************
  // framing decode
  // ********************
  // oversampled: serial clock must stay well below a quarter of the system clock
  wire active = ~sen_n_s2_r;
  wire rise = active & sclk_s2_r & ~sclk_s3_r;
  wire fall = active & ~sclk_s2_r & sclk_s3_r;
  wire [`SER_CNT_W-1:0] cnt_nxt = (cnt_r == `SER_CNT_MAX) ? cnt_r : cnt_r + 1'b1;
  wire [7:0] byte_in = {shin_r[6:0], sdio_s2_r};
  wire is_read = instr_r[`SER_RW_BIT];
  wire data_phase = cnt_r >= `SER_INSTR_EDGES;
  wire byte_done = (cnt_nxt == `SER_BYTE1_EDGES) ||
                   ((cnt_nxt == `SER_BYTE2_EDGES) && instr_r[`SER_TWO_BYTE_BIT]);
  wire reload = (cnt_r == `SER_INSTR_EDGES) || (cnt_r == `SER_BYTE1_EDGES);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      instr_r <= 8'h00;
      shin_r <= 8'h00;
      shout_r <= 8'h00;
      addr_r <= 6'h00;
      sdo_r <= 1'b0;
      oe_n_r <= 1'b1;
      wr_r <= '0;
    end
    else
    begin
      wr_r.en <= 1'b0;
      oe_n_r <= ~(active & is_read & data_phase);
      if (!active)
        cnt_r <= '0;
      else if (rise)
      begin
        cnt_r <= cnt_nxt;
        shin_r <= byte_in;
        if (cnt_nxt == `SER_INSTR_EDGES)
        begin
          instr_r <= byte_in;
          addr_r <= byte_in[5:0];
        end
        else if (byte_done)
        begin
          // a byte cut short by an aborted frame never reaches here, so partial writes are dropped
          wr_r.en <= ~is_read;
          wr_r.addr <= addr_r;
          wr_r.data <= byte_in;
          addr_r <= addr_r + 1'b1;
        end
      end
      else if (fall && is_read && data_phase)
      begin
        if (reload)
        begin
          sdo_r <= rd_data[7];
          shout_r <= {rd_data[6:0], 1'b0};
        end
        else
        begin
          sdo_r <= shout_r[7];
          shout_r <= {shout_r[6:0], 1'b0};
        end
      end
    end
  end

  assign sdo = sdo_r;
  assign sdo_oe_n = oe_n_r;
  assign rd_addr = addr_r;
  assign wr = wr_r;

endmodule : serial_reg_port
